/* File: bench/ctsd_core_properties.sv */
// port assertions for the test, swap and trap unit
`timescale 1ns/1ps
module ctsd_core_properties (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic [7:0] PM_DATA_I,
   input wire logic [15:0] PM_ADDR_O,
   input wire logic PM_RD_O,
   input wire logic [11:0] SP_O,
   input wire logic [7:0] FLAGS_O,
   input wire logic DONE_O,
   input wire logic ILLEGAL_O
);
   logic boot;
   logic opc;
   logic [7:0] op;
   logic [7:0] fl;
   logic [7:0] next_op;
   logic [7:0] next_fl;
   // an opcode is taken in the first cycle after reset and in every done cycle
   always_comb begin
      opc = DONE_O | boot;
      next_op = opc ? PM_DATA_I : op;
      next_fl = opc ? FLAGS_O : fl;
   end
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         boot <= 1'b1;
         op <= 8'h00;
         fl <= 8'h00;
      end else begin
         boot <= 1'b0;
         op <= next_op;
         fl <= next_fl;
      end
   end
   default clocking @(posedge CLK_I);
   endclocking
   default disable iff (SYS_RST_I);
   sequence s_x3;
      (!PM_RD_O) [*3] ##1 DONE_O;
   endsequence
   sequence s_x4;
      (!PM_RD_O) [*4] ##1 DONE_O;
   endsequence
   property p_ext;
      opc && PM_DATA_I inside {8'h28, 8'h29, 8'h68, 8'h69, 8'h78, 8'h79} |-> PM_RD_O [*4] ##1 s_x3;
   endproperty
   a_ext: assert property (p_ext) else $error("extended form length wrong");
   property p_f2x3;
      opc && PM_DATA_I inside {8'h62, 8'h72, 8'hf1} |-> PM_RD_O [*2] ##1 s_x3;
   endproperty
   a_f2x3: assert property (p_f2x3) else $error("2/3 form length wrong");
   property p_f2x4;
      opc && PM_DATA_I inside {8'h63, 8'h73} |-> PM_RD_O [*2] ##1 s_x4;
   endproperty
   a_f2x4: assert property (p_f2x4) else $error("2/4 form length wrong");
   property p_f3x3;
      opc && PM_DATA_I inside {8'h64, 8'h66, 8'h74, 8'h76} |-> PM_RD_O [*3] ##1 s_x3;
   endproperty
   a_f3x3: assert property (p_f3x3) else $error("3/3 form length wrong");
   property p_f3x4;
      opc && PM_DATA_I inside {8'h65, 8'h67, 8'h75, 8'h77} |-> PM_RD_O [*3] ##1 s_x4;
   endproperty
   a_f3x4: assert property (p_f3x4) else $error("3/4 form length wrong");
   property p_swap;
      opc && PM_DATA_I == 8'hf0 |-> PM_RD_O [*2] ##1 (!PM_RD_O) [*2] ##1 DONE_O;
   endproperty
   a_swap: assert property (p_swap) else $error("direct swap length wrong");
   property p_vcall;
      opc && PM_DATA_I == 8'hf2 |-> ##1 (!DONE_O) [*7] ##1
         (DONE_O && SP_O == $past(SP_O, 8) - 12'h003 && FLAGS_O == $past(FLAGS_O, 8));
   endproperty
   a_vcall: assert property (p_vcall) else $error("vector call wrong");
   property p_keep;
      DONE_O && op inside {[8'h62:8'h69], [8'h72:8'h79]} |->
         !FLAGS_O[4] && FLAGS_O[7] == fl[7] && FLAGS_O[3:2] == fl[3:2];
   endproperty
   a_keep: assert property (p_keep) else $error("mask test flags wrong");
   property p_subd;
      DONE_O && op inside {8'h28, 8'h29} |-> FLAGS_O[3];
   endproperty
   a_subd: assert property (p_subd) else $error("subtract decimal flag wrong");
   property p_ill;
      opc && !(PM_DATA_I inside {8'h28, 8'h29, [8'h62:8'h69], [8'h72:8'h79], [8'hf0:8'hf2]}) |->
         ##1 !PM_RD_O ##1 (DONE_O && ILLEGAL_O && PM_ADDR_O == $past(PM_ADDR_O, 2) + 16'h0001);
   endproperty
   a_ill: assert property (p_ill) else $error("unknown opcode handling wrong");
endmodule : ctsd_core_properties

/* File: bench/ctsd_pm_model.sv */
// program memory model answering opcode and operand reads
`timescale 1ns/1ps
module ctsd_pm_model (
   input wire logic clk_i,
   input wire logic rd_i,
   input wire logic [15:0] addr_i,
   output logic [7:0] data_o
);
   logic [7:0] mem [0:65535];
   logic [7:0] last;
   logic [7:0] next_last;
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'hff;
      end
   end
   // zero-latency read; a released bus shows the inverse of the last byte
   always_comb begin
      next_last = rd_i ? mem[addr_i] : last;
      data_o = rd_i ? mem[addr_i] : ~last;
   end
   always_ff @(posedge clk_i) begin
      last <= next_last;
   end
endmodule : ctsd_pm_model

/* File: bench/testbench.sv */
// self-checking bench for the test, swap and trap unit
`timescale 1ns/1ps
module testbench;
   typedef struct {
      logic [31:0] code;
      int len;
      int cyc;
      logic [7:0] fl;
      logic [7:0] msk;
      logic [11:0] da;
      logic [7:0] dv;
   } ctsd_row_t;
   logic CLK_I;
   logic SYS_RST_I;
   logic [7:0] PM_DATA_I;
   logic [11:0] DBG_ADDR_I;
   logic [15:0] PM_ADDR_O;
   logic PM_RD_O;
   logic [15:0] PC_O;
   logic [11:0] SP_O;
   logic [7:0] FLAGS_O;
   logic [7:0] DBG_DATA_O;
   logic DONE_O;
   logic ILLEGAL_O;
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   int last;
   logic [15:0] pc;
   // working registers sit at the stack top, where vector calls leave known bytes
   ctsd_row_t rows [25] = '{
      '{32'hf2800000, 2, 8, 8'h00, 8'hff, 12'hfff, 8'h02},
      '{32'h29030fff, 4, 7, 8'hac, 8'hff, 12'hfff, 8'hff},
      '{32'h72fe0000, 2, 5, 8'hcc, 8'hff, 12'h000, 8'h00},
      '{32'h62ef0000, 2, 5, 8'hac, 8'hff, 12'h000, 8'h00},
      '{32'h78ffdfff, 4, 7, 8'hcc, 8'hff, 12'h000, 8'h00},
      '{32'h69800ffe, 4, 7, 8'hac, 8'hff, 12'h000, 8'h00},
      '{32'h797f0fff, 4, 7, 8'h8c, 8'hff, 12'h000, 8'h00},
      '{32'h68ffefff, 4, 7, 8'hcc, 8'hff, 12'h000, 8'h00},
      '{32'h28fffffe, 4, 7, 8'h8c, 8'hff, 12'hffe, 8'h01},
      '{32'h29810ffe, 4, 7, 8'hb8, 8'hff, 12'hffe, 8'h80},
      '{32'h29800ffe, 4, 7, 8'h48, 8'hff, 12'hffe, 8'h00},
      '{32'hf2900000, 2, 8, 8'h48, 8'hff, 12'hffa, 8'h48},
      '{32'h63ef0000, 2, 6, 8'h08, 8'h9c, 12'h000, 8'h00},
      '{32'h64102000, 3, 6, 8'h08, 8'h9c, 12'h000, 8'h00},
      '{32'h65102000, 3, 7, 8'h08, 8'h9c, 12'h000, 8'h00},
      '{32'h66105500, 3, 6, 8'h08, 8'h9c, 12'h000, 8'h00},
      '{32'h67105500, 3, 7, 8'h08, 8'h9c, 12'h000, 8'h00},
      '{32'h73ef0000, 2, 6, 8'h08, 8'h9c, 12'h000, 8'h00},
      '{32'h74102000, 3, 6, 8'h08, 8'h9c, 12'h000, 8'h00},
      '{32'h75102000, 3, 7, 8'h08, 8'h9c, 12'h000, 8'h00},
      '{32'h76105500, 3, 6, 8'h08, 8'h9c, 12'h000, 8'h00},
      '{32'h77105500, 3, 7, 8'h08, 8'h9c, 12'h000, 8'h00},
      '{32'hf0100000, 2, 4, 8'h08, 8'h9c, 12'h000, 8'h00},
      '{32'hf1100000, 2, 5, 8'h08, 8'h9c, 12'h000, 8'h00},
      '{32'h22000000, 1, 2, 8'h08, 8'h9c, 12'h000, 8'h00}
   };
   ctsd_core i_dut (
      .CLK_I, .SYS_RST_I, .PM_DATA_I, .WRK_BASE_I(8'hff), .DBG_ADDR_I, .PM_ADDR_O, .PM_RD_O,
      .PC_O, .SP_O, .FLAGS_O, .DBG_DATA_O, .DONE_O, .ILLEGAL_O
   );
   ctsd_pm_model i_pm (.clk_i(CLK_I), .rd_i(PM_RD_O), .addr_i(PM_ADDR_O), .data_o(PM_DATA_I));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         @(posedge CLK_I);
         #1;
         n++;
      end while (DONE_O !== 1'b1 && n < 20);
   endtask : wait_done
   task automatic rst_chk();
      chk(PM_ADDR_O, 16'h0000);
      chk(16'(PM_RD_O), 16'h0001);
      chk(PC_O, 16'h0000);
      chk(16'(SP_O), 16'h0000);
      chk(16'(FLAGS_O), 16'h0000);
      chk(16'({DONE_O, ILLEGAL_O}), 16'h0000);
      chk(16'(DBG_DATA_O), 16'h0000);
   endtask : rst_chk
   task automatic wrap_up();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      CLK_I = 1'b0;
      forever #50 CLK_I = ~CLK_I;
   end
   always @(posedge CLK_I) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         wrap_up();
      end
   end
   initial begin
      SYS_RST_I = 1'b1;
      DBG_ADDR_I = 12'h000;
      pc = 16'h0000;
      #1;
      // vector words point just past each call, so the program runs straight on
      // the vector word sits at twice the vector, clear of the program bytes
      i_pm.mem[16'h0100] = 8'h00;
      i_pm.mem[16'h0101] = 8'h02;
      i_pm.mem[16'h0120] = 8'h00;
      i_pm.mem[16'h0121] = 8'h28;
      foreach (rows[i]) begin
         for (int b = 0; b < rows[i].len; b++) begin
            i_pm.mem[pc] = rows[i].code[31 - 8 * b -: 8];
            pc++;
         end
      end
      pc = 16'h0000;
      repeat (16) @(posedge CLK_I);
      #1;
      rst_chk();
      SYS_RST_I = 1'b0;
      last = cycles;
      foreach (rows[i]) begin
         wait_done();
         pc += 16'(rows[i].len);
         chk(16'(cycles - last), 16'(rows[i].cyc));
         last = cycles;
         chk(16'(FLAGS_O & rows[i].msk), 16'(rows[i].fl));
         chk(PC_O, pc);
         chk(16'(ILLEGAL_O), 16'(rows[i].len == 1));
         if (rows[i].da != 12'h000) begin
            DBG_ADDR_I = rows[i].da;
            @(posedge CLK_I);
            #1;
            chk(16'(DBG_DATA_O), 16'(rows[i].dv));
         end
      end
      // push order of the second call: pc high, pc low, then flags below
      chk(16'(SP_O), 16'h0ffa);
      DBG_ADDR_I = 12'hffb;
      @(posedge CLK_I);
      #1;
      DBG_ADDR_I = 12'hffc;
      chk(16'(DBG_DATA_O), 16'h0000);
      @(posedge CLK_I);
      #1;
      chk(16'(DBG_DATA_O), 16'h0028);
      SYS_RST_I = 1'b1;
      #1;
      rst_chk();
      @(posedge CLK_I);
      #1;
      SYS_RST_I = 1'b0;
      last = cycles;
      wait_done();
      chk(16'(cycles - last), 16'h0008);
      chk(PC_O, 16'h0002);
      chk(16'(SP_O), 16'h0ffd);
      wrap_up();
   end
endmodule : testbench

bind ctsd_core ctsd_core_properties i_prop (
   .CLK_I, .SYS_RST_I, .PM_DATA_I, .PM_ADDR_O, .PM_RD_O, .SP_O, .FLAGS_O, .DONE_O, .ILLEGAL_O
);

/* File: src/ctsd_alu.sv */
// result and flag computation for subtract, swap and mask tests
`timescale 1ns/1ps
module ctsd_alu (
   input wire ctsd_pkg::ctsd_alu_op_t op_i,
   input wire logic [7:0] dst_i,
   input wire logic [7:0] src_i,
   input wire logic [7:0] flags_i,
   output ctsd_pkg::ctsd_alu_res_t res_o
);
   logic [8:0] diff;
   logic [4:0] low_diff;
   logic [7:0] r;

   always_comb begin
      diff = {1'b0, dst_i} - {1'b0, src_i};
      low_diff = {1'b0, dst_i[3:0]} - {1'b0, src_i[3:0]};
      r = 8'h00;
      res_o.flags = flags_i;
      res_o.write = 1'b0;
      unique case (op_i)
         ctsd_pkg::ALU_SUB: begin
            r = diff[7:0];
            res_o.write = 1'b1;
            res_o.flags[ctsd_pkg::FLAG_C] = diff[8];
            res_o.flags[ctsd_pkg::FLAG_V] = (dst_i[7] != src_i[7]) && (r[7] != dst_i[7]);
            res_o.flags[ctsd_pkg::FLAG_D] = 1'b1;
            res_o.flags[ctsd_pkg::FLAG_H] = low_diff[4];
         end
         ctsd_pkg::ALU_SWAP: begin
            r = {dst_i[3:0], dst_i[7:4]};
            res_o.write = 1'b1;
         end
         ctsd_pkg::ALU_CMASK: begin
            r = ~dst_i & src_i;
            res_o.flags[ctsd_pkg::FLAG_V] = 1'b0;
         end
         ctsd_pkg::ALU_MASK: begin
            r = dst_i & src_i;
            res_o.flags[ctsd_pkg::FLAG_V] = 1'b0;
         end
         ctsd_pkg::ALU_PASS: begin
            r = dst_i;
         end
      endcase
      if (op_i != ctsd_pkg::ALU_PASS) begin
         res_o.flags[ctsd_pkg::FLAG_Z] = (r == 8'h00);
         res_o.flags[ctsd_pkg::FLAG_S] = r[7];
      end
      res_o.value = r;
   end
endmodule : ctsd_alu

/* File: src/ctsd_core.sv */
// fetch and execute unit for subtract, swap, mask tests and vector call
`timescale 1ns/1ps
module ctsd_core (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic [7:0] PM_DATA_I,
   input wire logic [7:0] WRK_BASE_I,
   input wire logic [11:0] DBG_ADDR_I,
   output logic [15:0] PM_ADDR_O,
   output logic PM_RD_O,
   output logic [15:0] PC_O,
   output logic [11:0] SP_O,
   output logic [7:0] FLAGS_O,
   output logic [7:0] DBG_DATA_O,
   output logic DONE_O,
   output logic ILLEGAL_O
);
   typedef enum logic {ST_FETCH, ST_EXEC} ctsd_state_t;

   ctsd_state_t state, next_state;
   logic [15:0] pc, next_pc;
   logic [11:0] sp, next_sp;
   logic [7:0] flags, next_flags;
   logic [7:0] ibuf [0:3];
   logic [7:0] next_ibuf [0:3];
   logic [2:0] fcnt, next_fcnt;
   logic [2:0] ecnt, next_ecnt;
   logic [15:0] pm_addr, next_pm_addr;
   logic pm_rd, next_pm_rd;
   logic [7:0] vec_hi, next_vec_hi;
   logic done, next_done;
   logic ill, next_ill;
   logic [7:0] dbg_data;

   logic [7:0] regs [0:4095];
   logic we;
   logic [11:0] waddr;
   logic [7:0] wdata;

   ctsd_pkg::ctsd_alu_op_t alu_op;
   logic [11:0] dst_addr;
   logic [7:0] dst_val, src_val;
   ctsd_pkg::ctsd_alu_res_t alu_res;
   logic [7:0] op;
   logic [2:0] len;

   // 8-bit register address into the 4K register space
   function automatic logic [11:0] raddr(input logic [7:0] a);
      raddr = {4'h0, a};
   endfunction : raddr

   function automatic logic [11:0] waddr_of(input logic [7:0] base, input logic [3:0] n);
      waddr_of = {base, n};
   endfunction : waddr_of

   assign op = ibuf[0];

   // operand decode
   always_comb begin
      alu_op = ctsd_pkg::ALU_PASS;
      dst_addr = 12'h000;
      src_val = 8'h00;
      unique case (op[7:4])
         4'h2, 4'h6, 4'h7: begin
            if (op[7:4] == 4'h2) begin
               alu_op = ctsd_pkg::ALU_SUB;
            end else if (op[7:4] == 4'h6) begin
               alu_op = ctsd_pkg::ALU_CMASK;
            end else begin
               alu_op = ctsd_pkg::ALU_MASK;
            end
            unique case (op[3:0])
               ctsd_pkg::FORM_WW: begin
                  dst_addr = waddr_of(WRK_BASE_I, ibuf[1][7:4]);
                  src_val = regs[waddr_of(WRK_BASE_I, ibuf[1][3:0])];
               end
               ctsd_pkg::FORM_WIW: begin
                  dst_addr = waddr_of(WRK_BASE_I, ibuf[1][7:4]);
                  src_val = regs[raddr(regs[waddr_of(WRK_BASE_I, ibuf[1][3:0])])];
               end
               ctsd_pkg::FORM_RR: begin
                  dst_addr = raddr(ibuf[2]);
                  src_val = regs[raddr(ibuf[1])];
               end
               ctsd_pkg::FORM_RIR: begin
                  dst_addr = raddr(ibuf[2]);
                  src_val = regs[raddr(regs[raddr(ibuf[1])])];
               end
               ctsd_pkg::FORM_RI: begin
                  dst_addr = raddr(ibuf[1]);
                  src_val = ibuf[2];
               end
               ctsd_pkg::FORM_IRI: begin
                  dst_addr = raddr(regs[raddr(ibuf[1])]);
                  src_val = ibuf[2];
               end
               ctsd_pkg::FORM_EE: begin
                  dst_addr = {ibuf[2][3:0], ibuf[3]};
                  src_val = regs[{ibuf[1], ibuf[2][7:4]}];
               end
               ctsd_pkg::FORM_EI: begin
                  dst_addr = {ibuf[2][3:0], ibuf[3]};
                  src_val = ibuf[1];
               end
               default: begin
                  alu_op = ctsd_pkg::ALU_PASS;
               end
            endcase
            // subtract exists only in the two extended forms
            if (op[7:4] == 4'h2 && op[3:0] != ctsd_pkg::FORM_EE && op[3:0] != ctsd_pkg::FORM_EI) begin
               alu_op = ctsd_pkg::ALU_PASS;
            end
         end
         4'hf: begin
            if (op == ctsd_pkg::OP_SWAP_R) begin
               alu_op = ctsd_pkg::ALU_SWAP;
               dst_addr = raddr(ibuf[1]);
            end else if (op == ctsd_pkg::OP_SWAP_IND) begin
               alu_op = ctsd_pkg::ALU_SWAP;
               dst_addr = raddr(regs[raddr(ibuf[1])]);
            end
         end
         default: begin
            alu_op = ctsd_pkg::ALU_PASS;
         end
      endcase
      dst_val = regs[dst_addr];
   end

   ctsd_alu u_alu (
      .op_i(alu_op),
      .dst_i(dst_val),
      .src_i(src_val),
      .flags_i(flags),
      .res_o(alu_res)
   );

   // sequencing
   always_comb begin
      next_state = state;
      next_pc = pc;
      next_sp = sp;
      next_flags = flags;
      for (int i = 0; i < 4; i++) begin
         next_ibuf[i] = ibuf[i];
      end
      next_fcnt = fcnt;
      next_ecnt = ecnt;
      next_pm_addr = pm_addr;
      next_pm_rd = pm_rd;
      next_vec_hi = vec_hi;
      next_done = 1'b0;
      next_ill = 1'b0;
      we = 1'b0;
      waddr = 12'h000;
      wdata = 8'h00;
      len = 3'h1;
      unique case (state)
         ST_FETCH: begin
            // one byte per fetch cycle until the whole instruction is held
            next_ibuf[fcnt[1:0]] = PM_DATA_I;
            next_pc = pc + 16'h0001;
            len = (fcnt == 3'h0) ? ctsd_pkg::fetch_len(PM_DATA_I) : ctsd_pkg::fetch_len(ibuf[0]);
            if (fcnt + 3'h1 == len) begin
               next_state = ST_EXEC;
               next_ecnt = 3'h1;
               next_pm_rd = 1'b0;
            end else begin
               next_fcnt = fcnt + 3'h1;
               next_pm_addr = pc + 16'h0001;
            end
         end
         ST_EXEC: begin
            len = ctsd_pkg::exec_len(op);
            next_ecnt = ecnt + 3'h1;
            if (op == ctsd_pkg::OP_VCALL) begin
               unique case (ecnt)
                  ctsd_pkg::VC_PUSH_HI: begin
                     next_sp = sp - ctsd_pkg::SP_DEC2;
                     we = 1'b1;
                     waddr = sp - ctsd_pkg::SP_DEC2;
                     wdata = pc[15:8];
                  end
                  ctsd_pkg::VC_PUSH_LO: begin
                     we = 1'b1;
                     waddr = sp + 12'h001;
                     wdata = pc[7:0];
                  end
                  ctsd_pkg::VC_DEC: begin
                     next_sp = sp - ctsd_pkg::SP_DEC1;
                  end
                  ctsd_pkg::VC_PUSH_FL: begin
                     we = 1'b1;
                     waddr = sp;
                     wdata = flags;
                     next_pm_addr = {7'h00, ibuf[1], 1'b0};
                     next_pm_rd = 1'b1;
                  end
                  ctsd_pkg::VC_VEC_HI: begin
                     next_vec_hi = PM_DATA_I;
                     next_pm_addr = pm_addr + 16'h0001;
                  end
                  ctsd_pkg::VC_VEC_LO: begin
                     next_pc = {vec_hi, PM_DATA_I};
                  end
                  default: begin
                     next_sp = sp;
                  end
               endcase
            end
            if (ecnt == len) begin
               // results land in the last execute cycle
               if (op != ctsd_pkg::OP_VCALL) begin
                  next_flags = alu_res.flags;
                  we = alu_res.write;
                  waddr = dst_addr;
                  wdata = alu_res.value;
               end
               next_ill = (ctsd_pkg::fetch_len(op) == ctsd_pkg::LEN_UNKNOWN) && (len == ctsd_pkg::LEN_UNKNOWN);
               next_done = 1'b1;
               next_state = ST_FETCH;
               next_fcnt = 3'h0;
               next_pm_addr = next_pc;
               next_pm_rd = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         state <= ST_FETCH;
         pc <= ctsd_pkg::RESET_PC;
         sp <= ctsd_pkg::RESET_SP;
         flags <= ctsd_pkg::RESET_FLAGS;
         for (int i = 0; i < 4; i++) begin
            ibuf[i] <= 8'h00;
         end
         fcnt <= 3'h0;
         ecnt <= 3'h0;
         pm_addr <= ctsd_pkg::RESET_PC;
         pm_rd <= 1'b1;
         vec_hi <= 8'h00;
         done <= 1'b0;
         ill <= 1'b0;
         dbg_data <= 8'h00;
      end else begin
         state <= next_state;
         pc <= next_pc;
         sp <= next_sp;
         flags <= next_flags;
         for (int i = 0; i < 4; i++) begin
            ibuf[i] <= next_ibuf[i];
         end
         fcnt <= next_fcnt;
         ecnt <= next_ecnt;
         pm_addr <= next_pm_addr;
         pm_rd <= next_pm_rd;
         vec_hi <= next_vec_hi;
         done <= next_done;
         ill <= next_ill;
         dbg_data <= regs[DBG_ADDR_I];
      end
   end

   // register space holds no reset; software must initialise it
   always_ff @(posedge CLK_I) begin
      if (we) begin
         regs[waddr] <= wdata;
      end
   end

   assign PM_ADDR_O = pm_addr;
   assign PM_RD_O = pm_rd;
   assign PC_O = pc;
   assign SP_O = sp;
   assign FLAGS_O = flags;
   assign DBG_DATA_O = dbg_data;
   assign DONE_O = done;
   assign ILLEGAL_O = ill;
endmodule : ctsd_core

/* File: src/ctsd_pkg.sv */
// constants, types and decode tables for the test, swap and trap instruction unit
// Functional notes
// - extended subtract stores dst minus src, D set
// - nibble swap exchanges halves; Z,S follow result
// - complement mask test: (not dst) and src
// - complement mask test fetch/execute cycles per form
// - extended complement mask test, four fetch, three execute
// - mask test: dst and src, V cleared
// - extended mask test, four fetch, three execute
// - vector call pushes PC, flags, loads vector
// - flag codes applied exactly per opcode
package ctsd_pkg;

   // flag register bit positions
   localparam int FLAG_C = 7;
   localparam int FLAG_Z = 6;
   localparam int FLAG_S = 5;
   localparam int FLAG_V = 4;
   localparam int FLAG_D = 3;
   localparam int FLAG_H = 2;

   // reset values
   localparam logic [15:0] RESET_PC = 16'h0000;
   localparam logic [11:0] RESET_SP = 12'h000;
   localparam logic [7:0] RESET_FLAGS = 8'h00;

   // opcodes
   localparam logic [7:0] OP_SUB_EE = 8'h28;
   localparam logic [7:0] OP_SUB_EI = 8'h29;
   localparam logic [7:0] OP_CM_WW = 8'h62;
   localparam logic [7:0] OP_CM_WIW = 8'h63;
   localparam logic [7:0] OP_CM_RR = 8'h64;
   localparam logic [7:0] OP_CM_RIR = 8'h65;
   localparam logic [7:0] OP_CM_RI = 8'h66;
   localparam logic [7:0] OP_CM_IRI = 8'h67;
   localparam logic [7:0] OP_CMX_EE = 8'h68;
   localparam logic [7:0] OP_CMX_EI = 8'h69;
   localparam logic [7:0] OP_M_WW = 8'h72;
   localparam logic [7:0] OP_M_WIW = 8'h73;
   localparam logic [7:0] OP_M_RR = 8'h74;
   localparam logic [7:0] OP_M_RIR = 8'h75;
   localparam logic [7:0] OP_M_RI = 8'h76;
   localparam logic [7:0] OP_M_IRI = 8'h77;
   localparam logic [7:0] OP_MX_EE = 8'h78;
   localparam logic [7:0] OP_MX_EI = 8'h79;
   localparam logic [7:0] OP_SWAP_R = 8'hf0;
   localparam logic [7:0] OP_SWAP_IND = 8'hf1;
   localparam logic [7:0] OP_VCALL = 8'hf2;

   // low nibble of the mask-test families selects the operand form
   localparam logic [3:0] FORM_WW = 4'h2;
   localparam logic [3:0] FORM_WIW = 4'h3;
   localparam logic [3:0] FORM_RR = 4'h4;
   localparam logic [3:0] FORM_RIR = 4'h5;
   localparam logic [3:0] FORM_RI = 4'h6;
   localparam logic [3:0] FORM_IRI = 4'h7;
   localparam logic [3:0] FORM_EE = 4'h8;
   localparam logic [3:0] FORM_EI = 4'h9;

   // vector call execute steps
   localparam logic [2:0] VC_PUSH_HI = 3'h1;
   localparam logic [2:0] VC_PUSH_LO = 3'h2;
   localparam logic [2:0] VC_DEC = 3'h3;
   localparam logic [2:0] VC_PUSH_FL = 3'h4;
   localparam logic [2:0] VC_VEC_HI = 3'h5;
   localparam logic [2:0] VC_VEC_LO = 3'h6;
   localparam logic [11:0] SP_DEC2 = 12'h002;
   localparam logic [11:0] SP_DEC1 = 12'h001;

   localparam logic [2:0] LEN_UNKNOWN = 3'h1;

   typedef enum logic [2:0] {ALU_PASS, ALU_SUB, ALU_SWAP, ALU_CMASK, ALU_MASK} ctsd_alu_op_t;

   typedef struct packed {
      logic [7:0] value;
      logic [7:0] flags;
      logic write;
   } ctsd_alu_res_t;

   // number of instruction bytes, opcode included
   function automatic logic [2:0] fetch_len(input logic [7:0] op);
      case (op)
         OP_SUB_EE, OP_SUB_EI, OP_CMX_EE, OP_CMX_EI, OP_MX_EE, OP_MX_EI: fetch_len = 3'h4;
         OP_CM_RR, OP_CM_RIR, OP_CM_RI, OP_CM_IRI, OP_M_RR, OP_M_RIR, OP_M_RI, OP_M_IRI: fetch_len = 3'h3;
         OP_CM_WW, OP_CM_WIW, OP_M_WW, OP_M_WIW, OP_SWAP_R, OP_SWAP_IND, OP_VCALL: fetch_len = 3'h2;
         default: fetch_len = LEN_UNKNOWN;
      endcase
   endfunction : fetch_len

   function automatic logic [2:0] exec_len(input logic [7:0] op);
      case (op)
         OP_SUB_EE, OP_SUB_EI, OP_CMX_EE, OP_CMX_EI, OP_MX_EE, OP_MX_EI: exec_len = 3'h3;
         OP_CM_WW, OP_CM_RR, OP_CM_RI, OP_M_WW, OP_M_RR, OP_M_RI, OP_SWAP_IND: exec_len = 3'h3;
         OP_CM_WIW, OP_CM_RIR, OP_CM_IRI, OP_M_WIW, OP_M_RIR, OP_M_IRI: exec_len = 3'h4;
         OP_SWAP_R: exec_len = 3'h2;
         OP_VCALL: exec_len = 3'h6;
         default: exec_len = LEN_UNKNOWN;
      endcase
   endfunction : exec_len

endpackage : ctsd_pkg
